// file: logic/hcoc_pkg.sv
/*
  Constants and types for the hold and clock output control block.
  Assumes one 25 MHz clock and a 32-bit Avalon-MM slave port.
*/
// What this block does
// - Bit 9 shows request pin, low means request.
// - Bit 8 shows grant pin, low means granted.
// - Ignore bit 0: grant requests as soon as possible.
// - Ignore bit 1: never grant the bus.
// - Float bit 1: clock A floats during grant.
// - Float bit 0: clock A keeps running during grant.
// - Bit 5 runs clock A; cleared holds it low.
// - Bit 4 runs divide-by-four clock; cleared holds high.
// - Divide-by-four clock runs after reset.
// - Divide-by-four pin shared with I/O line 1.
// - Bit 3 runs divide-by-six clock; cleared holds high.
// - Divide-by-six clock runs after reset.
// - Divide-by-six pin shared with I/O line 2.
// - Bits 2..0 read zero, writes ignored.
// - Divided clock enables only in primary instance.
// - Clock switching is not glitch-free.
package hcoc_pkg;
  localparam logic [4:0] HCOC_ADDR_GLB_CTL = 5'h00;
  localparam logic [4:0] HCOC_ADDR_IO_FUNC = 5'h04;
  localparam logic [4:0] HCOC_ADDR_IO_OUT = 5'h08;
  localparam logic [4:0] HCOC_ADDR_IO_DIR = 5'h0C;
  localparam logic [4:0] HCOC_ADDR_IO_IN = 5'h10;
  localparam int HCOC_BIT_HOLD_REQ = 9;
  localparam int HCOC_BIT_GRANT = 8;
  localparam int HCOC_BIT_IGNORE = 7;
  localparam int HCOC_BIT_FLOAT_A = 6;
  localparam int HCOC_BIT_EN_A = 5;
  localparam int HCOC_BIT_EN_DIV4 = 4;
  localparam int HCOC_BIT_EN_DIV6 = 3;
  localparam int HCOC_BIT_IO1 = 1;
  localparam int HCOC_BIT_IO2 = 2;
  localparam logic HCOC_RST_IGNORE = 1'b0;
  localparam logic HCOC_RST_FLOAT_A = 1'b1;
  localparam logic HCOC_RST_EN_A = 1'b1;
  localparam logic HCOC_RST_EN_DIV4 = 1'b1;
  localparam logic HCOC_RST_EN_DIV6 = 1'b1;
  localparam int HCOC_DIV4 = 4;
  localparam int HCOC_DIV6 = 6;

  typedef enum logic [1:0] {
    HCOC_OWN,
    HCOC_GRANTED
  } hcoc_hold_t;

  typedef struct packed {
    logic o;
    logic oe;
  } hcoc_pin_t;
endpackage

// file: logic/hcoc_clkdiv.sv
/*
  Divided clock generator: a square wave at clock/DIV.
  Assumes DIV even and at least 2; output parks high when disabled.
*/
`timescale 1ns/1ns
module hcoc_clkdiv import hcoc_pkg::*; #(
  parameter int DIV = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  output logic clk_out
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] HALF_LAST = CW'(DIV / 2 - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic level;
  } hcoc_div_t;

  hcoc_div_t s_q;
  hcoc_div_t s_d;

  always_comb begin
    s_d = s_q;
    if (!enable) begin
      s_d.cnt = '0;
      s_d.level = 1'b1;
    end else if (s_q.cnt == HALF_LAST) begin
      s_d.cnt = '0;
      s_d.level = !s_q.level;
    end else begin
      s_d.cnt = s_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '{cnt: '0, level: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign clk_out = s_q.level;
endmodule

// file: logic/hcoc_top.sv
/*
  Global interface control, low half: bus hold handshake and
  clock output controls, behind an Avalon-MM slave with waitrequest.
  Assumes hold_req_n comes from a pin in another domain, and that the
  memory controller on the same clock reports mem_busy and obeys hold_active.
*/
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ns
module hcoc_top import hcoc_pkg::*; #(
  parameter bit PRIMARY = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic hold_req_n,
  output logic bus_grant_ack_n,
  input wire logic mem_busy,
  output logic hold_active,
  output logic clkout_a_o,
  output logic clkout_a_oe,
  output logic div4_clock_out_o,
  output logic div4_clock_out_oe,
  output logic div6_clock_out_o,
  output logic div6_clock_out_oe,
  input wire logic [2:1] io_line_i
);
  typedef struct packed {
    logic wait_r;
    logic [31:0] rdata;
    logic [1:0] req_sync;
    logic [1:0] io1_sync;
    logic [1:0] io2_sync;
    hcoc_hold_t hold;
    logic ignore_bus_requests;
    logic clkout_a_float_in_grant;
    logic clkout_a_enable;
    logic div4_clock_enable;
    logic div6_clock_enable;
    logic [2:1] io_function_enable;
    logic [2:1] io_out;
    logic [2:1] io_dir;
    logic grant_n;
    logic hold_act;
    logic clk_a_level;
    hcoc_pin_t clk_a_pin;
    hcoc_pin_t div4_pin;
    hcoc_pin_t div6_pin;
  } hcoc_state_t;

  hcoc_state_t s_q;
  hcoc_state_t s_d;
  logic div4_raw;
  logic div6_raw;
  logic req_seen;
  logic access;
  logic commit_wr;
  logic [31:0] glb_view;
  logic [31:0] rd_mux;

  // Divided clocks run off the shared enables
  hcoc_clkdiv #(
    .DIV(HCOC_DIV4)
  ) u_div4 (
    .clock(clock),
    .rst(rst),
    .enable(s_q.div4_clock_enable),
    .clk_out(div4_raw)
  );

  hcoc_clkdiv #(
    .DIV(HCOC_DIV6)
  ) u_div6 (
    .clock(clock),
    .rst(rst),
    .enable(s_q.div6_clock_enable),
    .clk_out(div6_raw)
  );

  // Second stage only: request is active low
  assign req_seen = !s_q.req_sync[1];
  assign access = avs_read || avs_write;
  assign commit_wr = avs_write && !s_q.wait_r;

  always_comb begin
    glb_view = 32'h0000_0000;
    glb_view[HCOC_BIT_HOLD_REQ] = s_q.req_sync[1];
    glb_view[HCOC_BIT_GRANT] = s_q.grant_n;
    glb_view[HCOC_BIT_IGNORE] = s_q.ignore_bus_requests;
    glb_view[HCOC_BIT_FLOAT_A] = s_q.clkout_a_float_in_grant;
    glb_view[HCOC_BIT_EN_A] = s_q.clkout_a_enable;
    if (PRIMARY) begin
      glb_view[HCOC_BIT_EN_DIV4] = s_q.div4_clock_enable;
      glb_view[HCOC_BIT_EN_DIV6] = s_q.div6_clock_enable;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      HCOC_ADDR_GLB_CTL: begin
        rd_mux = glb_view;
      end
      HCOC_ADDR_IO_FUNC: begin
        rd_mux[2:1] = s_q.io_function_enable;
      end
      HCOC_ADDR_IO_OUT: begin
        rd_mux[2:1] = s_q.io_out;
      end
      HCOC_ADDR_IO_DIR: begin
        rd_mux[2:1] = s_q.io_dir;
      end
      HCOC_ADDR_IO_IN: begin
        rd_mux[HCOC_BIT_IO1] = s_q.io1_sync[1];
        rd_mux[HCOC_BIT_IO2] = s_q.io2_sync[1];
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;

    // Pin samples pass two flops first
    s_d.req_sync = {s_q.req_sync[0], hold_req_n};
    s_d.io1_sync = {s_q.io1_sync[0], io_line_i[1]};
    s_d.io2_sync = {s_q.io2_sync[0], io_line_i[2]};

    // Bus slave: one wait cycle, then answer
    if (access && s_q.wait_r) begin
      s_d.wait_r = 1'b0;
      s_d.rdata = avs_read ? rd_mux : 32'h0000_0000;
    end else begin
      s_d.wait_r = 1'b1;
    end

    if (commit_wr && avs_byteenable[0]) begin
      case (avs_address)
        HCOC_ADDR_GLB_CTL: begin
          s_d.ignore_bus_requests = avs_writedata[HCOC_BIT_IGNORE];
          s_d.clkout_a_float_in_grant = avs_writedata[HCOC_BIT_FLOAT_A];
          s_d.clkout_a_enable = avs_writedata[HCOC_BIT_EN_A];
          if (PRIMARY) begin
            s_d.div4_clock_enable = avs_writedata[HCOC_BIT_EN_DIV4];
            s_d.div6_clock_enable = avs_writedata[HCOC_BIT_EN_DIV6];
          end
        end
        HCOC_ADDR_IO_FUNC: begin
          s_d.io_function_enable = avs_writedata[2:1];
        end
        HCOC_ADDR_IO_OUT: begin
          s_d.io_out = avs_writedata[2:1];
        end
        HCOC_ADDR_IO_DIR: begin
          s_d.io_dir = avs_writedata[2:1];
        end
        default: begin
          s_d.io_out = s_q.io_out;
        end
      endcase
    end

    // Hold handshake
    case (s_q.hold)
      HCOC_OWN: begin
        if (req_seen && !s_q.ignore_bus_requests && !mem_busy) begin
          s_d.hold = HCOC_GRANTED;
        end
      end
      HCOC_GRANTED: begin
        if (!req_seen) begin
          s_d.hold = HCOC_OWN;
        end
      end
      default: begin
        s_d.hold = HCOC_OWN;
      end
    endcase
    s_d.grant_n = (s_d.hold != HCOC_GRANTED);
    s_d.hold_act = (s_d.hold == HCOC_GRANTED);

    // Clock A: half rate square wave, low when disabled
    if (s_q.clkout_a_enable) begin
      s_d.clk_a_level = !s_q.clk_a_level;
    end else begin
      s_d.clk_a_level = 1'b0;
    end
    s_d.clk_a_pin.o = s_d.clk_a_level;
    if (s_q.clkout_a_float_in_grant && s_d.hold == HCOC_GRANTED) begin
      s_d.clk_a_pin.oe = 1'b0;
    end else begin
      s_d.clk_a_pin.oe = 1'b1;
    end

    // Shared pins: divided clock or general-purpose line
    if (PRIMARY && !s_q.io_function_enable[HCOC_BIT_IO1]) begin
      s_d.div4_pin = '{o: div4_raw, oe: 1'b1};
    end else begin
      s_d.div4_pin = '{o: s_q.io_out[HCOC_BIT_IO1], oe: s_q.io_dir[HCOC_BIT_IO1]};
    end
    if (PRIMARY && !s_q.io_function_enable[HCOC_BIT_IO2]) begin
      s_d.div6_pin = '{o: div6_raw, oe: 1'b1};
    end else begin
      s_d.div6_pin = '{o: s_q.io_out[HCOC_BIT_IO2], oe: s_q.io_dir[HCOC_BIT_IO2]};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_q.wait_r <= 1'b1;
      s_q.rdata <= 32'h0000_0000;
      s_q.req_sync <= 2'h3;
      s_q.io1_sync <= 2'h0;
      s_q.io2_sync <= 2'h0;
      s_q.hold <= HCOC_OWN;
      s_q.ignore_bus_requests <= HCOC_RST_IGNORE;
      s_q.clkout_a_float_in_grant <= HCOC_RST_FLOAT_A;
      s_q.clkout_a_enable <= HCOC_RST_EN_A;
      s_q.div4_clock_enable <= HCOC_RST_EN_DIV4;
      s_q.div6_clock_enable <= HCOC_RST_EN_DIV6;
      s_q.io_function_enable <= 2'h0;
      s_q.io_out <= 2'h0;
      s_q.io_dir <= 2'h0;
      s_q.grant_n <= 1'b1;
      s_q.hold_act <= 1'b0;
      s_q.clk_a_level <= 1'b0;
      s_q.clk_a_pin <= '{o: 1'b0, oe: 1'b1};
      s_q.div4_pin <= '{o: 1'b1, oe: 1'b1};
      s_q.div6_pin <= '{o: 1'b1, oe: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.rdata;
  assign avs_waitrequest = s_q.wait_r;
  assign bus_grant_ack_n = s_q.grant_n;
  assign hold_active = s_q.hold_act;
  assign clkout_a_o = s_q.clk_a_pin.o;
  assign clkout_a_oe = s_q.clk_a_pin.oe;
  assign div4_clock_out_o = s_q.div4_pin.o;
  assign div4_clock_out_oe = s_q.div4_pin.oe;
  assign div6_clock_out_o = s_q.div6_pin.o;
  assign div6_clock_out_oe = s_q.div6_pin.oe;
endmodule

// file: verification/hcoc_top_sva.sv
/*
  Port checker for hcoc_top.
  Assumes one clock domain and reset rst, bound to every hcoc_top.
*/
`timescale 1ns/1ns
module hcoc_top_sva import hcoc_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic hold_req_n,
  input wire logic bus_grant_ack_n,
  input wire logic mem_busy,
  input wire logic hold_active,
  input wire logic clkout_a_o,
  input wire logic clkout_a_oe,
  input wire logic div4_clock_out_o,
  input wire logic div6_clock_out_o
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic ctl_ans;
  assign ctl_ans = avs_read && !avs_waitrequest && avs_address == HCOC_ADDR_GLB_CTL;
  property p_grant; $fell(bus_grant_ack_n) |-> !$past(mem_busy) && !$past(hold_req_n, 3); endproperty
  a_grant: assert property (p_grant) else $error("grant without cause");
  property p_release; $rose(hold_req_n) |-> ##3 bus_grant_ack_n; endproperty
  a_release: assert property (p_release) else $error("grant not released");
  property p_pair; bus_grant_ack_n != hold_active; endproperty
  a_pair: assert property (p_pair) else $error("grant and hold disagree");
  property p_float; !clkout_a_oe |-> !bus_grant_ack_n; endproperty
  a_float: assert property (p_float) else $error("clock A floats outside grant");
  property p_clka; clkout_a_o |=> !clkout_a_o; endproperty
  a_clka: assert property (p_clka) else $error("clock A high too long");
  property p_div4; $rose(div4_clock_out_o) |=> div4_clock_out_o; endproperty
  a_div4: assert property (p_div4) else $error("div4 high phase short");
  property p_div6; $rose(div6_clock_out_o) |=> div6_clock_out_o[*2]; endproperty
  a_div6: assert property (p_div6) else $error("div6 high phase short");
  property p_rsvd; ctl_ans |-> avs_readdata[2:0] == 3'h0 && avs_readdata[31:10] == 22'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_ack_bit; ctl_ans |-> avs_readdata[8] == $past(bus_grant_ack_n); endproperty
  a_ack_bit: assert property (p_ack_bit) else $error("grant status bit wrong");
  property p_req_bit; ctl_ans |-> avs_readdata[9] == $past(hold_req_n, 3); endproperty
  a_req_bit: assert property (p_req_bit) else $error("request status bit wrong");
endmodule
bind hcoc_top hcoc_top_sva hcoc_top_sva_inst (.clock, .rst, .avs_address, .avs_read, .avs_readdata,
  .avs_waitrequest, .hold_req_n, .bus_grant_ack_n, .mem_busy, .hold_active, .clkout_a_o, .clkout_a_oe,
  .div4_clock_out_o, .div6_clock_out_o);

// file: verification/hcoc_hold_master.sv
/*
  External master that asks for the memory bus.
  Assumes the bench raises want to request; pin is registered on clock.
*/
`timescale 1ns/1ns
module hcoc_hold_master (
  input wire logic clock,
  input wire logic want,
  output logic hold_req_n
);
  always @(posedge clock) begin
    hold_req_n <= !want;
  end
endmodule

// file: verification/tb_hold_and_clock_output_control.sv
/*
  Self-checking bench for hcoc_top.
  Assumes the checker is bound and the master model drives hold_req_n.
*/
`timescale 1ns/1ns
module tb_hold_and_clock_output_control import hcoc_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [3:0] avs_byteenable = 4'hF;
  logic avs_waitrequest, bus_grant_ack_n, hold_active, hold_req_n;
  logic mem_busy = 1'b0;
  logic want = 1'b0;
  logic clkout_a_o, clkout_a_oe, div4_clock_out_o, div4_clock_out_oe, div6_clock_out_o, div6_clock_out_oe;
  logic [2:1] io_line_i = 2'h2;
  int err_total = 0;
  int tests_run = 0;
  always #20 clock = ~clock;
  hcoc_top hcoc_top_inst (.clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .hold_req_n, .bus_grant_ack_n, .mem_busy, .hold_active, .clkout_a_o,
    .clkout_a_oe, .div4_clock_out_o, .div4_clock_out_oe, .div6_clock_out_o, .div6_clock_out_oe, .io_line_i);
  hcoc_hold_master hcoc_hold_master_inst (.clock, .want, .hold_req_n);
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk("readdata", e, q);
  endtask
  task automatic wait_grant(input logic e);
    repeat (12) if (bus_grant_ack_n !== e) @(posedge clock);
  endtask
  task automatic t_regs;
    rc(HCOC_ADDR_GLB_CTL, 32'h0000_0378);
    wr(HCOC_ADDR_GLB_CTL, 32'hFFFF_FFFF);
    rc(HCOC_ADDR_GLB_CTL, 32'h0000_03F8);
    wr(HCOC_ADDR_GLB_CTL, 32'h0000_00FF);
    rc(HCOC_ADDR_GLB_CTL, 32'h0000_03F8);
    rc(5'h14, 32'h0);
  endtask
  task automatic t_hold;
    logic s;
    want <= 1'b1;
    repeat (8) @(posedge clock);
    chk("grant_ignored", 32'h1, bus_grant_ack_n);
    rc(HCOC_ADDR_GLB_CTL, 32'h0000_01F8);
    wr(HCOC_ADDR_GLB_CTL, 32'h0000_0078);
    wait_grant(1'b0);
    chk("grant", 32'h0, bus_grant_ack_n);
    rc(HCOC_ADDR_GLB_CTL, 32'h0000_0078);
    chk("clka_oe_float", 32'h0, clkout_a_oe);
    wr(HCOC_ADDR_GLB_CTL, 32'h0000_0038);
    repeat (2) @(posedge clock);
    s = clkout_a_o;
    @(posedge clock);
    chk("clka_oe_run", 32'h1, clkout_a_oe);
    chk("clka_toggle", !s, clkout_a_o);
    want <= 1'b0;
    wait_grant(1'b1);
    chk("hold_active", 32'h0, hold_active);
  endtask
  task automatic t_busy;
    mem_busy <= 1'b1;
    want <= 1'b1;
    repeat (8) @(posedge clock);
    chk("grant_busy", 32'h1, bus_grant_ack_n);
    mem_busy <= 1'b0;
    wait_grant(1'b0);
    chk("grant_after_busy", 32'h0, bus_grant_ack_n);
    want <= 1'b0;
    wait_grant(1'b1);
  endtask
  task automatic t_clk;
    int n4, n6;
    logic p4, p6;
    wr(HCOC_ADDR_GLB_CTL, 32'h0000_0040);
    repeat (3) @(posedge clock);
    repeat (6) begin
      @(posedge clock);
      chk("clka_off", 32'h0, clkout_a_o);
      chk("div4_off", 32'h1, div4_clock_out_o);
      chk("div6_off", 32'h1, div6_clock_out_o);
    end
    wr(HCOC_ADDR_GLB_CTL, 32'h0000_0078);
    repeat (4) @(posedge clock);
    n4 = 0;
    n6 = 0;
    p4 = div4_clock_out_o;
    p6 = div6_clock_out_o;
    repeat (12) begin
      @(posedge clock);
      n4 += int'(div4_clock_out_o !== p4);
      n6 += int'(div6_clock_out_o !== p6);
      p4 = div4_clock_out_o;
      p6 = div6_clock_out_o;
    end
    chk("div4_edges", 32'd6, n4);
    chk("div6_edges", 32'd4, n6);
  endtask
  task automatic t_io;
    wr(HCOC_ADDR_IO_OUT, 32'h6);
    wr(HCOC_ADDR_IO_DIR, 32'h2);
    wr(HCOC_ADDR_IO_FUNC, 32'h6);
    repeat (3) @(posedge clock);
    chk("io1_oe", 32'h1, div4_clock_out_oe);
    chk("io2_oe", 32'h0, div6_clock_out_oe);
    chk("io1_out", 32'h1, div4_clock_out_o);
    rc(HCOC_ADDR_IO_IN, 32'h4);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    t_regs;
    t_hold;
    t_busy;
    t_clk;
    t_io;
    give_verdict;
  end
  initial begin
    #200000;
    err_total++;
    give_verdict;
  end
endmodule
